// [inc/lrf_pkg.sv]
/*
  Package for the local RAM / FIFO block: register offsets, reset values,
  mode encodings and the configuration carrier.
  Assumes a 100 MHz single clock and a 32-bit AXI4-Lite register bus.
*/
package lrf_pkg;

  localparam logic [7:0] LRF_CFG_OFS = 8'h00;
  localparam logic [7:0] LRF_THR_OFS = 8'h04;
  localparam logic [7:0] LRF_STAT_OFS = 8'h08;

  localparam int LRF_UNIT_W = 36;
  localparam int LRF_UNITS = 64;
  localparam int LRF_DATA_W = 144;

  // Width selections
  localparam logic [1:0] LRF_W72 = 2'b00;
  localparam logic [1:0] LRF_W36 = 2'b01;
  localparam logic [1:0] LRF_W144 = 2'b10;

  // Control modes
  localparam logic [1:0] LRF_MODE_BRAM = 2'b00;
  localparam logic [1:0] LRF_MODE_MLP = 2'b01;
  localparam logic [1:0] LRF_MODE_PRST = 2'b10;
  localparam logic [1:0] LRF_MODE_OFF = 2'b11;

  // Write data sources
  localparam logic [1:0] LRF_WD_BRAM = 2'b00;
  localparam logic [1:0] LRF_WD_MIX = 2'b01;
  localparam logic [1:0] LRF_WD_ACC = 2'b10;
  localparam logic [1:0] LRF_WD_MULTB = 2'b11;

  localparam logic [6:0] LRF_MAXVAL_RST = 7'h7f;
  localparam logic [6:0] LRF_AFULL_RST = 7'h3f;
  localparam logic [3:0] LRF_AEMPTY_RST = 4'h0;

  localparam logic [1:0] LRF_RESP_OKAY = 2'b00;
  localparam logic [1:0] LRF_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [13:0] rsvd;
    logic [1:0] wdata_mode;
    logic [1:0] out_mode;
    logic [1:0] in_mode;
    logic [1:0] read_width;
    logic [1:0] write_width;
    logic accum_sel;
    logic sync_mode;
    logic output_reset_async_select;
    logic reg_dout;
    logic clear_enable;
    logic fwft;
    logic ignore_flags;
    logic fifo_enable;
  } lrf_cfg_t;

  typedef struct packed {
    logic [0:0] rsvd3;
    logic [6:0] aempty_th;
    logic [0:0] rsvd2;
    logic [6:0] afull_th;
    logic [0:0] rsvd1;
    logic [6:0] rd_maxval;
    logic [0:0] rsvd0;
    logic [6:0] wr_maxval;
  } lrf_thr_t;

  localparam lrf_cfg_t LRF_CFG_RST = '0;
  localparam lrf_thr_t LRF_THR_RST = '{rsvd3: 1'b0, aempty_th: {3'h0, LRF_AEMPTY_RST},
      rsvd2: 1'b0, afull_th: LRF_AFULL_RST, rsvd1: 1'b0, rd_maxval: LRF_MAXVAL_RST,
      rsvd0: 1'b0, wr_maxval: LRF_MAXVAL_RST};

  typedef struct packed {
    logic empty;
    logic full;
    logic almost_empty;
    logic almost_full;
    logic write_error;
    logic read_error;
  } lrf_flags_t;

endpackage : lrf_pkg

// [rtl/lrf_top.sv]
/*
  Local RAM that works as a plain RAM or as a FIFO with wrapping address
  generators, configured over AXI4-Lite.
  Assumes all inputs are synchronous to core_clk_i; write and read sides
  share this one clock.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: Pointer at end value wraps to zero
// R2: Write pointer reset clears write pointer
// R3: Read pointer reset clears read pointer
// R4: Pointer-reset mode needs FIFO enabled
// R5: Full write changes nothing, pointer holds
// R6: Empty read keeps output, pointer holds
// R7: Ignore-flags: always store, read, advance
// R8: Write error on write while full
// R9: Sync mode bit selects clock relation; here it is only stored and read back, one clock
// R10: Output register bit selects read path
// R11: Reset-assertion bit picks sync/async reset
// R12: Clear enable zeroes memory on reset
// R13: Output register always cleared by reset
// R14: Width codes: 72x32, 36x64, 144x16
// R15: Input mode picks write address source
// R16: Output mode picks read control source
// R17: Write data source selection
// R18: Accumulator data packing with zero pads
// R19: End values 7F for normal FIFO
// R20: Almost-full threshold, default 3F
// R21: Almost-empty threshold 00..0F, default 0
// R22: FWFT presents oldest entry unrequested
// R23: Read error on read while empty
// R24: Pointer resets come on ce bits 9, 8
// R25: Flags keep computing in counter modes
module lrf_top
  import lrf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Block RAM side
  input wire logic [143:0] block_ram_write_data_i,
  input wire logic [5:0] bram_wr_addr_i,
  input wire logic bram_wr_en_i,
  input wire logic [5:0] bram_rd_addr_i,
  input wire logic bram_rd_en_i,
  // Multiplier side
  input wire logic [11:6] mlp_ce_i,
  input wire logic [7:0] mlp_expb_i,
  input wire logic mlp_reg_rst_n_i,
  input wire logic [71:0] mlp_din_i,
  input wire logic [71:0] multb_h_i,
  input wire logic [71:0] multb_l_i,
  input wire logic [47:0] accum_ab_i,
  input wire logic [47:0] accum_cd_i,
  // Results
  output logic [143:0] ram_dout_o,
  output logic empty_o,
  output logic full_o,
  output logic almost_empty_o,
  output logic almost_full_o,
  output logic write_error_o,
  output logic read_error_o
);

  lrf_cfg_t cfg_ff;
  lrf_thr_t thr_ff;
  lrf_flags_t flags_ff;
  lrf_flags_t nxt_flags;

  logic [LRF_UNIT_W-1:0] mem [LRF_UNITS];
  logic [6:0] wr_ptr_ff;
  logic [6:0] rd_ptr_ff;
  logic [143:0] rd_word_ff;
  logic [143:0] dout_ff;

  // AXI4-Lite slave
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go;
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign wr_go = aw_held_ff & w_held_ff & ~bvalid_ff;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      // Ready reopens only once the response is taken: one write at a time
      if (s_axi_awvalid_i && awready_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
        awready_ff <= 1'b0;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end else if (!aw_held_ff && (!bvalid_ff || s_axi_bready_i)) begin
        awready_ff <= 1'b1;
      end
      if (s_axi_wvalid_i && wready_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
        wready_ff <= 1'b0;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end else if (!w_held_ff && (!bvalid_ff || s_axi_bready_i)) begin
        wready_ff <= 1'b1;
      end
    end
  end

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_ff <= LRF_CFG_RST;
      thr_ff <= LRF_THR_RST;
      bvalid_ff <= 1'b0;
      bresp_ff <= LRF_RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= LRF_RESP_OKAY;
        if (awaddr_ff[7:2] == LRF_CFG_OFS[7:2]) begin
          cfg_ff <= strb_merge(cfg_ff, wdata_ff, wstrb_ff); // R9
          cfg_ff.rsvd <= '0;
        end else if (awaddr_ff[7:2] == LRF_THR_OFS[7:2]) begin
          thr_ff <= strb_merge(thr_ff, wdata_ff, wstrb_ff);
          thr_ff.rsvd0 <= 1'b0;
          thr_ff.rsvd1 <= 1'b0;
          thr_ff.rsvd2 <= 1'b0;
          thr_ff.rsvd3 <= 1'b0;
          // Almost-empty threshold only spans 00..0F
          thr_ff.aempty_th[6:4] <= 3'h0; // R21
        end else if (awaddr_ff[7:2] != LRF_STAT_OFS[7:2]) begin
          bresp_ff <= LRF_RESP_SLVERR;
        end
      end else if (bvalid_ff && s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= LRF_RESP_OKAY;
      arready_ff <= 1'b0;
    end else if (s_axi_arvalid_i && arready_ff) begin
      rvalid_ff <= 1'b1;
      arready_ff <= 1'b0;
      rresp_ff <= LRF_RESP_OKAY;
      if (s_axi_araddr_i[7:2] == LRF_CFG_OFS[7:2]) begin
        rdata_ff <= cfg_ff;
      end else if (s_axi_araddr_i[7:2] == LRF_THR_OFS[7:2]) begin
        rdata_ff <= thr_ff;
      end else if (s_axi_araddr_i[7:2] == LRF_STAT_OFS[7:2]) begin
        rdata_ff <= {10'h0, rd_ptr_ff, 1'b0, wr_ptr_ff, 1'b0, flags_ff};
      end else begin
        rdata_ff <= 32'h0;
        rresp_ff <= LRF_RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // Control source selection
  logic wr_en;
  logic rd_en;
  logic [5:0] wr_addr;
  logic [5:0] rd_addr;
  logic reg_rst_n;
  logic wr_ptr_rst;
  logic rd_ptr_rst;
  logic fifo_wr;
  logic fifo_rd;
  logic [143:0] wr_data;

  always_comb begin
    wr_en = 1'b0;
    wr_addr = 6'h0;
    wr_ptr_rst = 1'b0;
    case (cfg_ff.in_mode) // R15
      LRF_MODE_BRAM: begin
        wr_en = bram_wr_en_i;
        wr_addr = bram_wr_addr_i;
      end
      LRF_MODE_MLP: begin
        wr_en = mlp_ce_i[7];
        wr_addr = mlp_expb_i[7:2];
      end
      LRF_MODE_PRST: begin
        wr_en = mlp_ce_i[7];
        wr_ptr_rst = mlp_ce_i[9] & cfg_ff.fifo_enable; // R4 R24
      end
      default: begin
        wr_en = 1'b0;
      end
    endcase
  end

  always_comb begin
    rd_en = 1'b0;
    rd_addr = 6'h0;
    rd_ptr_rst = 1'b0;
    reg_rst_n = 1'b1;
    case (cfg_ff.out_mode) // R16
      LRF_MODE_BRAM: begin
        rd_en = bram_rd_en_i;
        rd_addr = bram_rd_addr_i;
      end
      LRF_MODE_MLP: begin
        rd_en = mlp_ce_i[6];
        rd_addr = {mlp_expb_i[1:0], mlp_ce_i[11:8]};
        reg_rst_n = mlp_reg_rst_n_i;
      end
      LRF_MODE_PRST: begin
        rd_en = mlp_ce_i[6];
        reg_rst_n = mlp_reg_rst_n_i;
        rd_ptr_rst = mlp_ce_i[8] & cfg_ff.fifo_enable; // R4 R24
      end
      default: begin
        rd_en = 1'b0;
      end
    endcase
  end

  // FIFO addressing only applies with the multiplier-side controls
  assign fifo_wr = cfg_ff.fifo_enable && cfg_ff.in_mode inside {LRF_MODE_MLP, LRF_MODE_PRST};
  assign fifo_rd = cfg_ff.fifo_enable && cfg_ff.out_mode inside {LRF_MODE_MLP, LRF_MODE_PRST};

  always_comb begin
    case (cfg_ff.wdata_mode) // R17
      LRF_WD_BRAM: wr_data = block_ram_write_data_i;
      LRF_WD_MIX: wr_data = {block_ram_write_data_i[71:0], mlp_din_i};
      LRF_WD_ACC: begin
        if (cfg_ff.accum_sel) begin
          wr_data = {72'h0, 12'h0, accum_ab_i[23:0], 12'h0, accum_cd_i[23:0]}; // R18
        end else begin
          wr_data = {24'h0, accum_ab_i, 24'h0, accum_cd_i}; // R18
        end
      end
      default: wr_data = {multb_h_i, multb_l_i};
    endcase
  end

  // Entry depth and first 36-bit unit of an entry for a width code
  function automatic logic [6:0] depth_of(input logic [1:0] w);
    case (w) // R14
      LRF_W36: return 7'd64;
      LRF_W144: return 7'd16;
      default: return 7'd32;
    endcase
  endfunction : depth_of

  function automatic logic [5:0] unit_base(input logic [5:0] e, input logic [1:0] w);
    case (w) // R14
      LRF_W36: return e;
      LRF_W144: return {e[3:0], 2'b00};
      default: return {e[4:0], 1'b0};
    endcase
  endfunction : unit_base

  function automatic logic [2:0] units_of(input logic [1:0] w);
    case (w)
      LRF_W36: return 3'd1;
      LRF_W144: return 3'd4;
      default: return 3'd2;
    endcase
  endfunction : units_of

  function automatic logic [6:0] ptr_inc(input logic [6:0] p, input logic [6:0] maxval);
    return (p == maxval) ? 7'h00 : p + 7'h01; // R1
  endfunction : ptr_inc

  // Occupancy in entries; stays meaningful only with matching widths
  logic [6:0] count;
  logic is_full;
  logic is_empty;
  logic wr_ok;
  logic rd_ok;
  logic [5:0] wr_entry;
  logic [5:0] rd_entry;

  assign count = wr_ptr_ff - rd_ptr_ff; // R25
  assign is_full = count >= depth_of(cfg_ff.write_width);
  assign is_empty = count == 7'h00;
  assign wr_ok = wr_en && (!fifo_wr || cfg_ff.ignore_flags || !is_full); // R5 R7
  assign rd_ok = rd_en && (!fifo_rd || cfg_ff.ignore_flags || !is_empty); // R6 R7
  assign wr_entry = fifo_wr ? wr_ptr_ff[5:0] & 6'(depth_of(cfg_ff.write_width) - 7'd1) : wr_addr;
  assign rd_entry = fifo_rd ? rd_ptr_ff[5:0] & 6'(depth_of(cfg_ff.read_width) - 7'd1) : rd_addr;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= 7'h00;
    end else if (wr_ptr_rst) begin
      wr_ptr_ff <= 7'h00; // R2
    end else if (fifo_wr && wr_ok) begin
      wr_ptr_ff <= ptr_inc(wr_ptr_ff, thr_ff.wr_maxval); // R1 R7 R19
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_ptr_ff <= 7'h00;
    end else if (rd_ptr_rst) begin
      rd_ptr_ff <= 7'h00; // R3
    end else if (fifo_rd && rd_ok) begin
      rd_ptr_ff <= ptr_inc(rd_ptr_ff, thr_ff.rd_maxval); // R1 R7 R19
    end
  end

  // Memory: clear wins over a write in the same cycle
  logic [5:0] wr_base;
  assign wr_base = unit_base(wr_entry, cfg_ff.write_width);

  always_ff @(posedge core_clk_i) begin
    if (!reg_rst_n && cfg_ff.clear_enable) begin
      for (int i = 0; i < LRF_UNITS; i++) begin
        mem[i] <= '0; // R12
      end
    end else if (wr_ok) begin
      for (int i = 0; i < 4; i++) begin
        if (3'(i) < units_of(cfg_ff.write_width)) begin
          mem[6'(wr_base + 6'(i))] <= wr_data[LRF_UNIT_W*i +: LRF_UNIT_W];
        end
      end
    end
  end

  logic [5:0] rd_base;
  logic [143:0] rd_word;
  logic load_word;

  assign rd_base = unit_base(rd_entry, cfg_ff.read_width);

  always_comb begin
    rd_word = '0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < units_of(cfg_ff.read_width)) begin
        rd_word[LRF_UNIT_W*i +: LRF_UNIT_W] = mem[6'(rd_base + 6'(i))];
      end
    end
  end

  // FWFT shows the head entry whether or not a read is asked for
  assign load_word = (fifo_rd && cfg_ff.fwft) ? !is_empty : rd_ok; // R6 R22

  // Read output register; reset may act ahead of the clock when selected
  logic out_arst_n;
  assign out_arst_n = ~(cfg_ff.reg_dout & cfg_ff.output_reset_async_select & ~reg_rst_n);

  always_ff @(posedge core_clk_i or negedge out_arst_n) begin
    if (!out_arst_n) begin
      rd_word_ff <= '0; // R11 R13
    end else if (!rst_n_i || !reg_rst_n) begin
      rd_word_ff <= '0; // R11 R13
    end else if (load_word) begin
      rd_word_ff <= rd_word;
    end
  end

  // Unregistered path still lands in one flop so the port is clean
  always_ff @(posedge core_clk_i or negedge out_arst_n) begin
    if (!out_arst_n) begin
      dout_ff <= '0;
    end else if (!rst_n_i || !reg_rst_n) begin
      dout_ff <= '0; // R13
    end else if (cfg_ff.reg_dout) begin
      dout_ff <= rd_word_ff; // R10
    end else if (load_word) begin
      dout_ff <= rd_word; // R10
    end
  end

  // Sync mode only informs software here; both sides share one clock
  always_comb begin
    nxt_flags.empty = is_empty; // R25
    nxt_flags.full = is_full;
    nxt_flags.almost_full = count >= thr_ff.afull_th; // R20
    nxt_flags.almost_empty = count <= thr_ff.aempty_th; // R21
    nxt_flags.write_error = fifo_wr && wr_en && is_full; // R8
    nxt_flags.read_error = fifo_rd && rd_en && is_empty; // R23
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign ram_dout_o = dout_ff;
  assign empty_o = flags_ff.empty;
  assign full_o = flags_ff.full;
  assign almost_empty_o = flags_ff.almost_empty;
  assign almost_full_o = flags_ff.almost_full;
  assign write_error_o = flags_ff.write_error;
  assign read_error_o = flags_ff.read_error;

endmodule : lrf_top

`default_nettype wire

// [sim/lrf_monitor.sv]
/*
  Port-level checks for the local RAM/FIFO top, bound to every lrf_top.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lrf_monitor (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic bram_wr_en_i,
  input wire logic bram_rd_en_i,
  input wire logic [11:6] mlp_ce_i,
  input wire logic empty_o,
  input wire logic full_o,
  input wire logic almost_empty_o,
  input wire logic write_error_o,
  input wire logic read_error_o
);
  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Flags lag pointer state by a cycle, so either side of the edge counts
  werr_cause_a: assert property (
    write_error_o |-> $past(mlp_ce_i[7] | bram_wr_en_i) && (full_o || $past(full_o)))
    else $error("write error without a write into a full buffer");
  rerr_cause_a: assert property (
    read_error_o |-> $past(mlp_ce_i[6] | bram_rd_en_i) && (empty_o || $past(empty_o)))
    else $error("read error without a read from an empty buffer");
  flags_excl_a: assert property (!(full_o && empty_o))
    else $error("full and empty together");
  empty_aempty_a: assert property (empty_o |-> almost_empty_o)
    else $error("empty without almost empty");
  bresp_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped or changed");
  rdata_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read response dropped or changed");
  aw_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while response pending");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");

  werr_c: cover property (write_error_o);
  rerr_c: cover property (read_error_o);
  full_c: cover property (full_o);
endmodule : lrf_monitor

bind lrf_top lrf_monitor mon_u (.*);
`default_nettype wire

// [sim/lrf_mac_model.sv]
/*
  Behavioural multiplier-side source: write/read enables, pointer resets
  and write data. Drives only just after rising clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module lrf_mac_model (
  input wire logic clk_i,
  output logic [11:6] ce_o,
  output logic [7:0] expb_o,
  output logic reg_rst_n_o,
  output logic [71:0] din_o
);
  initial begin
    ce_o = 6'h00;
    expb_o = 8'h00;
    reg_rst_n_o = 1'b1;
    din_o = 72'h0;
  end

  task push(input logic [71:0] d);
    @(posedge clk_i);
    ce_o[7] <= 1'b1;
    din_o <= d;
    @(posedge clk_i);
    ce_o[7] <= 1'b0;
    // Released bus shows no stale value
    din_o <= ~d;
  endtask : push

  task pop;
    @(posedge clk_i);
    ce_o[6] <= 1'b1;
    @(posedge clk_i);
    ce_o[6] <= 1'b0;
  endtask : pop

  task prst;
    @(posedge clk_i);
    ce_o[9:8] <= 2'b11;
    @(posedge clk_i);
    ce_o[9:8] <= 2'b00;
  endtask : prst

  task rrst;
    @(posedge clk_i);
    reg_rst_n_o <= 1'b0;
    @(posedge clk_i);
    reg_rst_n_o <= 1'b1;
  endtask : rrst
endmodule : lrf_mac_model
`default_nettype wire

// [sim/local_ram_fifo_addr_gen_tb.sv]
/*
  Self-checking bench for lrf_top: AXI4-Lite register tasks plus the
  multiplier-side model feeding FIFO and counter-mode traffic.
*/
`timescale 1ns/1ps
`default_nettype none
module local_ram_fifo_addr_gen_tb;
  import lrf_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00;
  logic [7:0] s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'h0;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [143:0] block_ram_write_data_i = {72'h77_0000_0000_0000_0000, 72'hab_cdef_0123_4567_89ab};
  logic [5:0] bram_wr_addr_i = 6'h00;
  logic [5:0] bram_rd_addr_i = 6'h00;
  logic bram_wr_en_i = 1'b0;
  logic bram_rd_en_i = 1'b0;
  logic [11:6] mlp_ce_i;
  logic [7:0] mlp_expb_i;
  logic mlp_reg_rst_n_i;
  logic [71:0] mlp_din_i;
  wire [71:0] multb_h_i = mlp_din_i;
  wire [71:0] multb_l_i = ~mlp_din_i;
  wire [47:0] accum_ab_i = mlp_din_i[47:0];
  wire [47:0] accum_cd_i = mlp_din_i[71:24];
  logic [143:0] ram_dout_o;
  logic empty_o, full_o, almost_empty_o, almost_full_o, write_error_o, read_error_o;
  logic werr_seen = 1'b0;
  logic rerr_seen = 1'b0;
  logic [31:0] rd_v;
  logic [1:0] rd_r;
  logic [1:0] wr_r;
  logic [71:0] fw;
  int n_mismatch = 0;
  int check_count = 0;

  lrf_top dut_u (.*);
  lrf_mac_model mac_u (.clk_i(core_clk_i), .ce_o(mlp_ce_i), .expb_o(mlp_expb_i),
    .reg_rst_n_o(mlp_reg_rst_n_i), .din_o(mlp_din_i));

  always #5 core_clk_i = ~core_clk_i;

  // Error outputs are pulses, so keep a sticky copy
  always @(posedge core_clk_i) begin
    if (write_error_o === 1'b1)
      werr_seen <= 1'b1;
    if (read_error_o === 1'b1)
      rerr_seen <= 1'b1;
  end

  function automatic logic [71:0] dv(input int i);
    return 72'h12_3456_789a_bcde_f000 + 72'(i);
  endfunction : dv

  task chk(input logic [143:0] got, input logic [143:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task give_verdict;
    $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic b_t;
    b_t = 1'b0;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= 4'hf;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    // Handshakes judged on the values seen at each rising edge
    while (!b_t) begin
      @(posedge core_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o)
        s_axi_wvalid_i <= 1'b0;
      b_t = s_axi_bvalid_o;
      wr_r = s_axi_bresp_o;
    end
    s_axi_bready_i <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    logic r_t;
    r_t = 1'b0;
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (!r_t) begin
      @(posedge core_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o)
        s_axi_arvalid_i <= 1'b0;
      r_t = s_axi_rvalid_o;
      rd_v = s_axi_rdata_o;
      rd_r = s_axi_rresp_o;
    end
    s_axi_rready_i <= 1'b0;
  endtask : axi_rd

  task pop_chk(input logic [71:0] d);
    mac_u.pop();
    @(posedge core_clk_i);
    #1;
    chk(ram_dout_o, {block_ram_write_data_i[71:0], d});
  endtask : pop_chk

  task settle;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : settle

  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    axi_rd(LRF_CFG_OFS);
    chk(rd_v, 32'h0);
    axi_rd(LRF_THR_OFS);
    chk(rd_v, LRF_THR_RST);
    axi_rd(LRF_STAT_OFS);
    chk(rd_v[5:3], 3'b101);
    axi_rd(8'h0c);
    chk(rd_r, LRF_RESP_SLVERR);
    axi_wr(8'h0c, 32'h0);
    chk(wr_r, LRF_RESP_SLVERR);
    // FIFO, 144 x 16, mixed write data, multiplier-side controls
    axi_wr(LRF_CFG_OFS, 32'h0001_5a01);
    chk(wr_r, LRF_RESP_OKAY);
    axi_rd(LRF_CFG_OFS);
    chk(rd_v, 32'h0001_5a01);
    for (int i = 0; i < 17; i++)
      mac_u.push(dv(i));
    settle();
    chk(full_o, 1'b1);
    chk(werr_seen, 1'b1);
    axi_rd(LRF_STAT_OFS);
    chk(rd_v[13:7], 7'd16);
    chk(rd_v[5:0], 6'h10);
    axi_wr(LRF_THR_OFS, 32'hff10_7f7f);
    axi_rd(LRF_THR_OFS);
    chk(rd_v, 32'h0f10_7f7f);
    settle();
    chk({almost_full_o, almost_empty_o}, 2'h2);
    for (int i = 0; i < 16; i++)
      pop_chk(dv(i));
    settle();
    chk(empty_o, 1'b1);
    chk({almost_full_o, almost_empty_o}, 2'h1);
    chk(rerr_seen, 1'b0);
    pop_chk(dv(15));
    settle();
    chk(rerr_seen, 1'b1);
    // Counter mode: end values 2, flags ignored, pointer resets
    axi_wr(LRF_THR_OFS, 32'h003f_0202);
    axi_wr(LRF_CFG_OFS, 32'h0001_aa03);
    mac_u.prst();
    axi_rd(LRF_STAT_OFS);
    chk(rd_v[21:7], 15'h0);
    for (int i = 20; i < 24; i++)
      mac_u.push(dv(i));
    axi_rd(LRF_STAT_OFS);
    chk(rd_v[13:7], 7'd1);
    pop_chk(dv(23));
    pop_chk(dv(21));
    pop_chk(dv(22));
    // FWFT behind the output register, 72 x 32, accumulator data, clear
    mac_u.prst();
    axi_wr(LRF_THR_OFS, 32'h003f_7f7f);
    axi_wr(LRF_CFG_OFS, 32'h0002_509d);
    fw = dv(30);
    mac_u.push(fw);
    settle();
    chk(ram_dout_o, {72'h0, 12'h0, fw[23:0], 12'h0, fw[47:24]});
    mac_u.rrst();
    settle();
    chk(ram_dout_o, 144'h0);
    give_verdict();
  end

  initial begin
    #300000;
    n_mismatch++;
    give_verdict();
  end
endmodule : local_ram_fifo_addr_gen_tb
`default_nettype wire
